/* stm_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
module stm_analog_model #(
  parameter int STARTUP_NS = 202
) (
  input wire logic reference_enable,
  input wire logic comparator_enable,
  input wire logic [3:0] trip_level_select,
  input wire logic external_threshold_select,
  input wire logic [7:0] supply_level,
  input wire logic [7:0] external_threshold_level,
  output logic supply_at_or_above,
  output logic reference_stable_raw,
  output logic bandgap_ready_raw
);
  logic idle_pattern = 1'b0;
  logic stable = 1'b0;
  logic [7:0] threshold;
  int epoch = 0;
  // Unpowered comparator output wanders, off the clock edges
  initial begin
    #2.5;
    forever #5 idle_pattern = ~idle_pattern;
  end
  assign threshold = external_threshold_select ? external_threshold_level
                                               : {trip_level_select, 4'h8};
  assign supply_at_or_above = comparator_enable ? (supply_level >= threshold)
                                                : idle_pattern;
  // Settling timed in ns, restarts whenever reference powers up
  always @(reference_enable) begin
    epoch = epoch + 1;
    stable = 1'b0;
    if (reference_enable === 1'b1) begin
      fork
        automatic int e = epoch;
        begin
          #STARTUP_NS;
          if (e == epoch) stable = 1'b1;
        end
      join_none
    end
  end
  assign reference_stable_raw = stable;
  assign bandgap_ready_raw = stable;
endmodule : stm_analog_model
`default_nettype wire

/* stm_ctrl.sv */
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module stm_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [stm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [stm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [stm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [stm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_at_or_above,
  input wire logic bandgap_ready_raw,
  input wire logic reference_stable_raw,
  input wire logic brownout_ref_request,
  output logic comparator_enable,
  output logic divider_enable,
  output logic reference_enable,
  output logic [stm_pkg::LVL_W-1:0] trip_level_select,
  output logic external_threshold_select,
  output logic irq_request,
  output logic wake_request,
  output logic vector_on_wake
);
  import stm_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Analog inputs into the clock domain
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic cmp_s;
  logic bandgap_s;
  logic ref_s;
  logic bor_s;

  assign raw_in[SY_CMP] = supply_at_or_above;
  assign raw_in[SY_BANDGAP] = bandgap_ready_raw;
  assign raw_in[SY_REF] = reference_stable_raw;
  assign raw_in[SY_BOR] = brownout_ref_request;

  stm_sync #(.WIDTH(SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign cmp_s = sync_in[SY_CMP];
  assign bandgap_s = sync_in[SY_BANDGAP];
  assign ref_s = sync_in[SY_REF];
  assign bor_s = sync_in[SY_BOR];

  ////////////////////////////////////////////////////////////////////
  // Write channel
  stm_wr_state_t wr_state;
  stm_wr_state_t next_wr_state;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] next_aw_addr_q;
  logic [DATA_W-1:0] w_data_q;
  logic [DATA_W-1:0] next_w_data_q;
  logic [3:0] w_strb_q;
  logic [3:0] next_w_strb_q;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;

  assign s_axi_awready = (wr_state == WR_IDLE) || (wr_state == WR_HAVE_W);
  assign s_axi_wready = (wr_state == WR_IDLE) || (wr_state == WR_HAVE_AW);
  assign s_axi_bvalid = (wr_state == WR_RESP);
  assign s_axi_bresp = bresp;

  always_comb begin
    next_wr_state = wr_state;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_strb_q = w_strb_q;
    do_write = 1'b0;
    wr_addr = s_axi_awaddr;
    wr_data = s_axi_wdata;
    wr_strb = s_axi_wstrb;
    case (wr_state)
      WR_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          do_write = 1'b1;
          next_wr_state = WR_RESP;
        end else if (s_axi_awvalid) begin
          next_aw_addr_q = s_axi_awaddr;
          next_wr_state = WR_HAVE_AW;
        end else if (s_axi_wvalid) begin
          next_w_data_q = s_axi_wdata;
          next_w_strb_q = s_axi_wstrb;
          next_wr_state = WR_HAVE_W;
        end
      end
      WR_HAVE_AW: begin
        wr_addr = aw_addr_q;
        if (s_axi_wvalid) begin
          do_write = 1'b1;
          next_wr_state = WR_RESP;
        end
      end
      WR_HAVE_W: begin
        wr_data = w_data_q;
        wr_strb = w_strb_q;
        if (s_axi_awvalid) begin
          do_write = 1'b1;
          next_wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = WR_IDLE;
        end
      end
      default: begin
        next_wr_state = WR_IDLE;
      end
    endcase
    next_bresp = bresp;
    if (do_write) begin
      if (wr_addr == OFS_CONTROL || wr_addr == OFS_FLAG || wr_addr == OFS_IRQ_ENABLE) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Monitor state
  logic direction;
  logic next_direction;
  logic power_enable;
  logic next_power_enable;
  logic [LVL_W-1:0] level;
  logic [LVL_W-1:0] next_level;
  logic event_flag;
  logic next_event_flag;
  logic event_irq_en;
  logic next_event_irq_en;
  logic global_irq_en;
  logic next_global_irq_en;
  logic next_reference_enable;
  logic next_irq_request;
  logic next_wake_request;
  logic next_vector_on_wake;
  logic ref_stable_status;
  logic crossing;
  logic event_set;
  logic flag_clear;
  logic ctrl_write;
  logic ien_write;

  assign ctrl_write = do_write && wr_strb[0] && (wr_addr == OFS_CONTROL);
  assign ien_write = do_write && wr_strb[0] && (wr_addr == OFS_IRQ_ENABLE);
  // Write one to clear
  assign flag_clear = do_write && wr_strb[0] && (wr_addr == OFS_FLAG) && wr_data[BIT_EVENT_FLAG];
  // Stability comes from the analog side, no cycle count
  assign ref_stable_status = power_enable && ref_s;
  assign crossing = direction ? cmp_s : !cmp_s;
  assign event_set = ref_stable_status && crossing;

  always_comb begin
    next_direction = direction;
    next_power_enable = power_enable;
    next_level = level;
    next_event_irq_en = event_irq_en;
    next_global_irq_en = global_irq_en;
    if (ctrl_write) begin
      next_direction = wr_data[BIT_DIRECTION];
      next_power_enable = wr_data[BIT_POWER_ENABLE];
      next_level = wr_data[LVL_LSB +: LVL_W];
    end
    if (ien_write) begin
      next_event_irq_en = wr_data[BIT_EVENT_IRQ_EN];
      next_global_irq_en = wr_data[BIT_GLOBAL_IRQ_EN];
    end
    // Set wins over clear; flag holds until cleared
    next_event_flag = (event_flag && !flag_clear) || event_set;
    next_reference_enable = next_power_enable || bor_s;
    next_irq_request = next_event_flag && next_event_irq_en && next_global_irq_en;
    next_wake_request = next_event_flag && next_power_enable;
    next_vector_on_wake = next_wake_request && next_global_irq_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bresp <= RESP_OKAY;
      direction <= LEVEL_RESET_BIT;
      power_enable <= LEVEL_RESET_BIT;
      level <= LVL_RESET;
      event_flag <= LEVEL_RESET_BIT;
      event_irq_en <= LEVEL_RESET_BIT;
      global_irq_en <= LEVEL_RESET_BIT;
      reference_enable <= LEVEL_RESET_BIT;
      irq_request <= LEVEL_RESET_BIT;
      wake_request <= LEVEL_RESET_BIT;
      vector_on_wake <= LEVEL_RESET_BIT;
    end else begin
      wr_state <= next_wr_state;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_strb_q <= next_w_strb_q;
      bresp <= next_bresp;
      direction <= next_direction;
      power_enable <= next_power_enable;
      level <= next_level;
      event_flag <= next_event_flag;
      event_irq_en <= next_event_irq_en;
      global_irq_en <= next_global_irq_en;
      reference_enable <= next_reference_enable;
      irq_request <= next_irq_request;
      wake_request <= next_wake_request;
      vector_on_wake <= next_vector_on_wake;
    end
  end

  // Comparator and divider enables follow the power enable flop
  assign comparator_enable = power_enable;
  assign divider_enable = power_enable;
  assign trip_level_select = level;
  assign external_threshold_select = (level == LVL_EXTERNAL);

  ////////////////////////////////////////////////////////////////////
  // Read channel
  logic rvalid;
  logic next_rvalid;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CONTROL: begin
          next_rdata[BIT_DIRECTION] = direction;
          next_rdata[BIT_BANDGAP_READY] = bandgap_s;
          next_rdata[BIT_REF_STABLE] = ref_stable_status;
          next_rdata[BIT_POWER_ENABLE] = power_enable;
          next_rdata[LVL_LSB +: LVL_W] = level;
        end
        OFS_FLAG: begin
          next_rdata[BIT_EVENT_FLAG] = event_flag;
        end
        OFS_IRQ_ENABLE: begin
          next_rdata[BIT_EVENT_IRQ_EN] = event_irq_en;
          next_rdata[BIT_GLOBAL_IRQ_EN] = global_irq_en;
        end
        default: begin
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 3) |-> cmp_s == $past(supply_at_or_above, 2))
    else $error("comparator not delayed two flops");

  a_flag_on_event: assert property (@(posedge aclk) disable iff (!aresetn)
    event_set |=> event_flag && irq_request == (event_irq_en && global_irq_en))
    else $error("event did not set flag or irq");

  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    event_flag && !flag_clear |=> event_flag)
    else $error("flag dropped without clear");

  a_flag_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(event_flag) |-> $past(power_enable && ref_s && crossing))
    else $error("flag set before reference stable");

  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_request |-> event_flag && event_irq_en && global_irq_en)
    else $error("irq without all enables");

  a_ext_route: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_write && wr_data[LVL_LSB +: LVL_W] == LVL_EXTERNAL |=> external_threshold_select)
    else $error("external pin not selected");

  a_power_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_write && !wr_data[BIT_POWER_ENABLE] |=> !comparator_enable && !divider_enable
      ##1 !wake_request)
    else $error("analog left enabled");

  a_ref_shared: assert property (@(posedge aclk) disable iff (!aresetn)
    bor_s |=> reference_enable)
    else $error("reference dropped while shared");

  a_vector_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_on_wake |-> wake_request && global_irq_en)
    else $error("vector without global enable");

  a_reset_off: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> !power_enable && !direction && level == LVL_RESET && !event_flag)
    else $error("control not reset");
endmodule : stm_ctrl
`default_nettype wire

/* stm_pkg.sv */
`default_nettype none
package stm_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LVL_W = 4;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h08;
  // Control register fields
  localparam int BIT_DIRECTION = 7;
  localparam int BIT_BANDGAP_READY = 6;
  localparam int BIT_REF_STABLE = 5;
  localparam int BIT_POWER_ENABLE = 4;
  localparam int LVL_LSB = 0;
  // Flag and enable register fields
  localparam int BIT_EVENT_FLAG = 0;
  localparam int BIT_EVENT_IRQ_EN = 0;
  localparam int BIT_GLOBAL_IRQ_EN = 1;
  // Reset values
  localparam logic [LVL_W-1:0] LVL_RESET = 4'h0;
  localparam logic LEVEL_RESET_BIT = 1'b0;
  // Trip code that routes the external threshold pin
  localparam logic [LVL_W-1:0] LVL_EXTERNAL = 4'hF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchroniser lanes
  localparam int SYNC_W = 4;
  localparam int SY_CMP = 0;
  localparam int SY_BANDGAP = 1;
  localparam int SY_REF = 2;
  localparam int SY_BOR = 3;
  typedef enum logic [1:0] {WR_IDLE, WR_HAVE_AW, WR_HAVE_W, WR_RESP} stm_wr_state_t;
endpackage : stm_pkg
`default_nettype wire

/* stm_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module stm_sync #(
  parameter int WIDTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;

  ////////////////////////////////////////////////////////////////////
  // Two flops per lane
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stage_one[g] <= 1'b0;
          stage_two[g] <= 1'b0;
        end else begin
          stage_one[g] <= async_in[g];
          stage_two[g] <= stage_one[g];
        end
      end
    end
  endgenerate

  assign sync_out = stage_two;
endmodule : stm_sync
`default_nettype wire

/* test_supply_threshold_monitor_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module test_supply_threshold_monitor_ctrl;
  import stm_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [31:0] wd;
    logic [1:0] r;
    logic [31:0] rd;
  } stm_tb_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rdv;
  logic cmp_out, bg_raw, ref_raw, cmp_en, div_en, ref_en, ext_sel, irq, wake, vec;
  logic brownout = 1'b0;
  logic [3:0] lvl;
  logic [7:0] supply = 8'hFF;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  stm_tb_row_t rows[7];
  always #4 aclk = ~aclk;
  stm_ctrl uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_at_or_above(cmp_out), .bandgap_ready_raw(bg_raw), .reference_stable_raw(ref_raw),
    .brownout_ref_request(brownout), .comparator_enable(cmp_en), .divider_enable(div_en),
    .reference_enable(ref_en), .trip_level_select(lvl), .external_threshold_select(ext_sel),
    .irq_request(irq), .wake_request(wake), .vector_on_wake(vec));
  stm_analog_model analog (.reference_enable(ref_en), .comparator_enable(cmp_en),
    .trip_level_select(lvl), .external_threshold_select(ext_sel), .supply_level(supply),
    .external_threshold_level(8'h40), .supply_at_or_above(cmp_out),
    .reference_stable_raw(ref_raw), .bandgap_ready_raw(bg_raw));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        check(bresp, r);
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rd(a, rdv, rsp);
    check(rdv, d);
    check(rsp, r);
  endtask : rd_chk
  task automatic wait_stable;
    do rd(OFS_CONTROL, rdv, rsp); while (rdv[BIT_REF_STABLE] !== 1'b1);
  endtask : wait_stable
  ////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    rows = '{'{OFS_CONTROL, 32'h8F, RESP_OKAY, 32'h8F},
             '{OFS_CONTROL, 32'hFFFFFF6A, RESP_OKAY, 32'h0A},
             '{OFS_IRQ_ENABLE, 32'h03, RESP_OKAY, 32'h03},
             '{OFS_IRQ_ENABLE, 32'h00, RESP_OKAY, 32'h00},
             '{OFS_FLAG, 32'h01, RESP_OKAY, 32'h00},
             '{8'h0C, 32'hFF, RESP_SLVERR, 32'h00},
             '{8'h40, 32'h01, RESP_SLVERR, 32'h00}};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFS_CONTROL, 32'h00, RESP_OKAY);
    rd_chk(OFS_FLAG, 32'h00, RESP_OKAY);
    check(cmp_en, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd, rows[i].r);
      rd_chk(rows[i].a, rows[i].rd, rows[i].r);
    end
    for (int l = 0; l < 16; l++) begin
      wr(OFS_CONTROL, l, RESP_OKAY);
      check(lvl, l);
      check(ext_sel, l == 15);
    end
    // Falling detection, excursion during reference settling
    wr(OFS_CONTROL, 32'h05, RESP_OKAY);
    wr(OFS_CONTROL, 32'h15, RESP_OKAY);
    check({cmp_en, div_en}, 2'b11);
    rd_chk(OFS_CONTROL, 32'h15, RESP_OKAY);
    supply <= 8'h00;
    repeat (4) @(posedge aclk);
    supply <= 8'hFF;
    wait_stable();
    check(rdv, 32'h75);
    rd_chk(OFS_FLAG, 32'h00, RESP_OKAY);
    wr(OFS_FLAG, 32'h01, RESP_OKAY);
    supply <= 8'h57;
    repeat (6) @(posedge aclk);
    rd_chk(OFS_FLAG, 32'h01, RESP_OKAY);
    check({wake, irq, vec}, 3'b100);
    supply <= 8'hFF;
    repeat (6) @(posedge aclk);
    rd_chk(OFS_FLAG, 32'h01, RESP_OKAY);
    wr(OFS_IRQ_ENABLE, 32'h01, RESP_OKAY);
    check(irq, 1'b0);
    wr(OFS_IRQ_ENABLE, 32'h03, RESP_OKAY);
    check({irq, vec}, 2'b11);
    wr(OFS_FLAG, 32'h01, RESP_OKAY);
    @(posedge aclk);
    check({irq, wake}, 2'b00);
    // Rising detection after disable, reference restarts
    wr(OFS_CONTROL, 32'h05, RESP_OKAY);
    check({cmp_en, div_en, ref_en}, 3'b000);
    wr(OFS_CONTROL, 32'h85, RESP_OKAY);
    wr(OFS_CONTROL, 32'h95, RESP_OKAY);
    rd_chk(OFS_CONTROL, 32'h95, RESP_OKAY);
    wait_stable();
    repeat (6) @(posedge aclk);
    rd_chk(OFS_FLAG, 32'h01, RESP_OKAY);
    // Shared reference kept alive by the other user
    brownout <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(OFS_CONTROL, 32'h05, RESP_OKAY);
    check(ref_en, 1'b1);
    repeat (40) @(posedge aclk);
    check(ref_en, 1'b1);
    wr(OFS_CONTROL, 32'h15, RESP_OKAY);
    rd_chk(OFS_CONTROL, 32'h75, RESP_OKAY);
    brownout <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({cmp_en, irq, wake}, 3'b000);
    rd_chk(OFS_CONTROL, 32'h00, RESP_OKAY);
    end_sim();
  end
endmodule : test_supply_threshold_monitor_ctrl
`default_nettype wire
